// *** cosc_defs.svh ***
// constants for the clock output stop and spread control block
`ifndef COSC_DEFS_SVH
`define COSC_DEFS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define COSC_AW          4
`define COSC_OFF_CTRL    4'h0
`define COSC_OFF_STAT    4'h4
`define COSC_OFF_ID      4'h8
`define COSC_ID_VAL      32'h0000_005A
// ----------------------------------------
// control word fields
// ----------------------------------------
`define COSC_CW          13
`define COSC_CTRL_RST    13'h0382
`define COSC_SS_DEPTH_RST 2'b01
`define COSC_B_DUAL      0
`define COSC_B_SS_LO     1
`define COSC_B_SS_HI     2
`define COSC_B_SS_TYPE   3
`define COSC_B_SS_EN     4
`define COSC_B_TRI_A     5
`define COSC_B_TRI_B     6
`define COSC_B_CPU_CLOCK_STOP_N   7
`define COSC_B_FREE_RUNNING_PCI_CLK_STP  10
`define COSC_BE0_HI      7
`define COSC_BE1_LO      8
// ----------------------------------------
// status word fields
// ----------------------------------------
`define COSC_S_CPU       0
`define COSC_S_PD        3
`define COSC_S_PLL       4
`define COSC_S_ST        5
// ----------------------------------------
// clock source indices
// ----------------------------------------
`define COSC_NSRC        8
`define COSC_I_CPU       0
`define COSC_I_FREE_RUNNING_PCI_CLK      1
`define COSC_I_B66       2
`define COSC_I_M66       3
`define COSC_I_M48       4
`define COSC_I_PCI       5
`define COSC_I_REF       6
`define COSC_I_DUAL      7
// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define COSC_NCPU        3
`define COSC_NPCIF       3
`define COSC_PD_EDGES    2'd2
`define COSC_CPU_FALLS   2'd2
`define COSC_CLK_NS      10
`define COSC_WAKE_US     3000
`define COSC_WAKE_CYC    ((`COSC_WAKE_US * 1000) / `COSC_CLK_NS - 1)
`define COSC_WCW         19
`endif

// *** cosc_pkg.sv ***
// types for the clock output stop and spread control block
`include "cosc_defs.svh"
package cosc_pkg;
  typedef enum logic [6:0] {
    COSC_RUN       = 7'h01,
    COSC_ARM_DONE  = 7'h02,
    COSC_STOP_FREE_RUNNING_PCI_CLK = 7'h04,
    COSC_STOP_B66  = 7'h08,
    COSC_STOP_REST = 7'h10,
    COSC_OFF       = 7'h20,
    COSC_WAKE      = 7'h40
  } cosc_state_e;

  typedef struct packed {
    logic                            pd_s1;
    logic                            pd_s2;
    logic                            cs_s1;
    logic                            cs_s2;
    logic                            ps_s1;
    logic                            ps_s2;
    cosc_state_e                     st;
    logic [1:0]                      edge_cnt;
    logic [`COSC_WCW-1:0]            wake_cnt;
    logic [`COSC_NSRC-1:0]           prev;
    logic [`COSC_NPCIF-1:0]          free_running_pci_clk_run;
    logic [`COSC_NPCIF-1:0]          free_running_pci_clk_ps;
    logic                            pci_ps;
    logic                            pci_run;
    logic                            b66_run;
    logic                            dual_run;
    logic                            usb_run;
    logic                            ref_run;
    logic [`COSC_NCPU-1:0]           cpu_stop;
    logic [`COSC_NCPU-1:0][1:0]      cpu_falls;
    logic [`COSC_NPCIF-1:0]          free_running_pci_clk_o;
    logic                            pci_o;
    logic                            b66_o;
    logic                            dual_o;
    logic                            usb_o;
    logic                            ref_o;
    logic [`COSC_NCPU-1:0]           cpu_t;
    logic [`COSC_NCPU-1:0]           cpu_t_oe;
    logic [`COSC_NCPU-1:0]           cpu_c;
    logic [`COSC_NCPU-1:0]           cpu_c_oe;
    logic                            iref2;
    logic                            pll_en;
    logic                            ss_center;
    logic [1:0]                      ss_depth;
    logic                            ss_en;
    logic                            dual_ss;
    logic [`COSC_CW-1:0]             ctrl;
    logic                            wait_r;
    logic [31:0]                     rdata;
  } cosc_state_s;
endpackage : cosc_pkg

// *** cosc_top.sv ***
// clock output stop, power-down sequencing and spread control
//
// What this block does
// RL1 - decode three spread bits: top bit down or center, low two pick depth
// RL2 - free-running pci outputs may be stopped by pci stop input when configured
// RL3 - dual-function output powers up in 66 MHz mode; bit set selects 48 MHz
// RL4 - in 66 MHz mode the dual-function output is spread when spreading is on
// RL5 - in 48 MHz mode dual-function output is unspread and aligned to 48 MHz outputs
// RL6 - controller should choose 48 MHz mode at system power-on
// RL7 - switching dual-function output to 48 MHz while running may glitch
// RL8 - power-down input is asynchronous active low and synchronized internally
// RL9 - in power-down all clocks except cpu true held low, oscillator and plls powered off
// RL10 - every output stops synchronously, no glitches or short pulses
// RL11 - two cpu complement rises with power-down low stop free pci at fall
// RL12 - then buffered 66 stops, then the rest at own falls except cpu true
// RL13 - in power-down cpu true held high at twice iref, complement undriven
// RL14 - generator shuts down only after the last output has stopped
// RL15 - after power-down release all outputs run again within 3.0 ms
// RL16 - cpu stop input is active low and stops only cpu outputs
// RL17 - stoppable cpu pairs stop after two falling edges sample cpu stop
// RL18 - stopped cpu true stays driven high at normal current, complement undriven
// RL19 - stopped cpu pairs restart synchronously with no short or long pulses
// RL20 - restart latency at most two cpu complement cycles
// RL21 - spread bits reset to down spread of 0.50 percent
// RL22 - two bits choose driven or three-state cpu outputs when stopped
// RL23 - non-stoppable cpu pairs keep running during cpu stop
// RL24 - each stop input passes a two-flop synchronizer before use
`timescale 1ns/1ps
module cosc_top
  import cosc_pkg::*;
#(
  parameter int unsigned PD_WAKE_CYC = `COSC_WAKE_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [`COSC_AW-1:0]    avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   power_down_n,
  input  wire logic                   cpu_clock_stop_n,
  input  wire logic                   pci_clock_stop_n,
  input  wire logic                   cpu_src,
  input  wire logic                   free_running_pci_clk_src,
  input  wire logic                   b66_src,
  input  wire logic                   m66_src,
  input  wire logic                   m48_src,
  input  wire logic                   pci_src,
  input  wire logic                   ref_src,
  output logic [`COSC_NPCIF-1:0]      free_running_pci_clk,
  output logic                        pci_clk,
  output logic                        buffered_66m_clk,
  output logic                        dual_function_clk_out,
  output logic                        usb_48m_clk,
  output logic                        ref_clk,
  output logic [`COSC_NCPU-1:0]       cpu_clk_true,
  output logic [`COSC_NCPU-1:0]       cpu_clk_true_oe,
  output logic [`COSC_NCPU-1:0]       cpu_clk_complement,
  output logic [`COSC_NCPU-1:0]       cpu_clk_complement_oe,
  output logic                        cpu_true_iref_x2,
  output logic                        osc_pll_enable,
  output logic                        spread_center,
  output logic [1:0]                  spread_depth,
  output logic                        spread_modulation,
  output logic                        dual_spread_modulation
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cosc_state_s q;
  cosc_state_s d;

  logic [`COSC_NSRC-1:0] src;
  logic [`COSC_NSRC-1:0] fall;
  logic [`COSC_NSRC-1:0] rise;
  logic                  video_48m_mode;
  logic [2:0]            cpu_clock_stop_n_en;
  logic [2:0]            free_running_pci_clk_stp_en;
  logic                  pd_act;
  logic                  cpu_tri;

  // source levels and their edges
  assign video_48m_mode = q.ctrl[`COSC_B_DUAL];
  assign src = {video_48m_mode ? m48_src : m66_src, ref_src, pci_src,
                m48_src, m66_src, b66_src, free_running_pci_clk_src, cpu_src};
  assign fall = q.prev & ~src;
  assign rise = ~q.prev & src;
  assign cpu_clock_stop_n_en  = q.ctrl[`COSC_B_CPU_CLOCK_STOP_N +: `COSC_NCPU];
  assign free_running_pci_clk_stp_en = q.ctrl[`COSC_B_FREE_RUNNING_PCI_CLK_STP +: `COSC_NPCIF];
  assign pd_act = (q.st != COSC_RUN);
  // RL22 stopped drive choice
  assign cpu_tri = pd_act ? (q.ctrl[`COSC_B_TRI_A] | q.ctrl[`COSC_B_TRI_B])
                          : q.ctrl[`COSC_B_TRI_B];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.prev = src;
    // RL24 two-flop stop input synchronizers
    d.cs_s1 = cpu_clock_stop_n;
    d.cs_s2 = q.cs_s1;
    d.ps_s1 = pci_clock_stop_n;
    d.ps_s2 = q.ps_s1;
    // RL8 power-down synchronizer
    d.pd_s1 = power_down_n;
    d.pd_s2 = q.pd_s1;

    // power-down sequencer
    case (q.st)
      COSC_RUN: begin
        // RL11 count cpu complement rises with power-down low
        if (q.pd_s2) begin
          d.edge_cnt = '0;
        end else if (fall[`COSC_I_CPU]) begin
          d.edge_cnt = q.edge_cnt + 2'd1;
          if (q.edge_cnt + 2'd1 == `COSC_PD_EDGES) begin
            d.st = COSC_STOP_FREE_RUNNING_PCI_CLK;
          end
        end
      end
      COSC_ARM_DONE: begin
        d.st = COSC_STOP_FREE_RUNNING_PCI_CLK;
      end
      COSC_STOP_FREE_RUNNING_PCI_CLK: begin
        // RL11 free pci stops low at its falling edge
        if (fall[`COSC_I_FREE_RUNNING_PCI_CLK]) begin
          d.free_running_pci_clk_run = '0;
          d.st = COSC_STOP_B66;
        end
      end
      COSC_STOP_B66: begin
        // RL12 buffered 66 stops next
        if (fall[`COSC_I_B66]) begin
          d.b66_run = 1'b0;
          d.st = COSC_STOP_REST;
        end
      end
      COSC_STOP_REST: begin
        // RL12 remaining outputs stop at their own falls
        if (fall[`COSC_I_PCI]) begin
          d.pci_run = 1'b0;
        end
        if (fall[`COSC_I_DUAL]) begin
          d.dual_run = 1'b0;
        end
        if (fall[`COSC_I_M48]) begin
          d.usb_run = 1'b0;
        end
        if (fall[`COSC_I_REF]) begin
          d.ref_run = 1'b0;
        end
        // RL13 cpu true freezes high at its rise
        if (rise[`COSC_I_CPU]) begin
          d.cpu_stop = '1;
        end
        // RL14 shut down only after the last stop
        if (!(q.pci_run | q.dual_run | q.usb_run | q.ref_run)
            && (&q.cpu_stop)) begin
          d.st = COSC_OFF;
          d.pll_en = 1'b0;
        end
      end
      COSC_OFF: begin
        // RL9 oscillator and plls off while held
        d.pll_en = 1'b0;
        if (q.pd_s2) begin
          d.st = COSC_WAKE;
          d.pll_en = 1'b1;
          d.wake_cnt = '0;
        end
      end
      COSC_WAKE: begin
        // RL15 bounded relock wait then restart
        if (!q.pd_s2) begin
          d.st = COSC_OFF;
          d.pll_en = 1'b0;
        end else if (q.wake_cnt == `COSC_WCW'(PD_WAKE_CYC)) begin
          d.st = COSC_RUN;
          d.edge_cnt = '0;
          d.free_running_pci_clk_run = '1;
          d.pci_run = 1'b1;
          d.b66_run = 1'b1;
          d.dual_run = 1'b1;
          d.usb_run = 1'b1;
          d.ref_run = 1'b1;
          d.cpu_stop = '0;
          d.cpu_falls = '0;
        end else begin
          d.wake_cnt = q.wake_cnt + `COSC_WCW'(1);
        end
      end
      default: begin
        d.st = COSC_RUN;
      end
    endcase

    // RL16 cpu stop gates only the cpu pairs
    for (int i = 0; i < `COSC_NCPU; i++) begin
      if (q.st == COSC_RUN) begin
        if (cpu_clock_stop_n_en[i] && !q.cs_s2) begin
          // RL17 two falls sample the stop, then freeze high
          if (fall[`COSC_I_CPU] && q.cpu_falls[i] != `COSC_CPU_FALLS) begin
            d.cpu_falls[i] = q.cpu_falls[i] + 2'd1;
          end
          if (rise[`COSC_I_CPU] && q.cpu_falls[i] == `COSC_CPU_FALLS) begin
            d.cpu_stop[i] = 1'b1;
          end
        end else begin
          // RL23 non-stoppable pairs run on
          d.cpu_falls[i] = '0;
          // RL19 resume on a source fall, no short pulse
          // RL20 restart within one cpu cycle
          if (q.cpu_stop[i] && fall[`COSC_I_CPU]) begin
            d.cpu_stop[i] = 1'b0;
          end
        end
      end
    end

    // RL2 pci stop gating taken at each clock's falling edge
    for (int i = 0; i < `COSC_NPCIF; i++) begin
      if (fall[`COSC_I_FREE_RUNNING_PCI_CLK]) begin
        d.free_running_pci_clk_ps[i] = free_running_pci_clk_stp_en[i] & ~q.ps_s2;
      end
    end
    if (fall[`COSC_I_PCI]) begin
      d.pci_ps = ~q.ps_s2;
    end

    // RL10 gated outputs stop only at a fall of their source
    for (int i = 0; i < `COSC_NPCIF; i++) begin
      d.free_running_pci_clk_o[i] = src[`COSC_I_FREE_RUNNING_PCI_CLK] & q.free_running_pci_clk_run[i] & ~q.free_running_pci_clk_ps[i];
    end
    d.pci_o  = src[`COSC_I_PCI] & q.pci_run & ~q.pci_ps;
    d.b66_o  = src[`COSC_I_B66] & q.b66_run;
    // RL7 mode change may cut the current pulse
    d.dual_o = src[`COSC_I_DUAL] & q.dual_run;
    d.usb_o  = src[`COSC_I_M48] & q.usb_run;
    d.ref_o  = src[`COSC_I_REF] & q.ref_run;

    // cpu pins
    for (int i = 0; i < `COSC_NCPU; i++) begin
      // RL18 stopped true high, complement released
      d.cpu_t[i]    = q.cpu_stop[i] | src[`COSC_I_CPU];
      d.cpu_t_oe[i] = ~(q.cpu_stop[i] & cpu_tri);
      d.cpu_c[i]    = ~q.cpu_stop[i] & ~src[`COSC_I_CPU];
      d.cpu_c_oe[i] = ~q.cpu_stop[i];
    end
    // RL13 twice iref during power-down
    d.iref2 = pd_act;

    // RL1 spread decode
    d.ss_center = q.ctrl[`COSC_B_SS_TYPE];
    d.ss_depth  = q.ctrl[`COSC_B_SS_HI:`COSC_B_SS_LO];
    d.ss_en     = q.ctrl[`COSC_B_SS_EN] & q.pll_en;
    // RL4 spread the 66 mode only
    // RL5 48 mode stays unspread
    d.dual_ss   = q.ctrl[`COSC_B_SS_EN] & q.pll_en & ~video_48m_mode;

    // avalon slave: one wait cycle, then the access completes
    d.wait_r = 1'b1;
    if (q.wait_r && (avs_read || avs_write)) begin
      d.wait_r = 1'b0;
      case (avs_address)
        `COSC_OFF_CTRL: begin
          d.rdata = {{(32 - `COSC_CW){1'b0}}, q.ctrl};
        end
        `COSC_OFF_STAT: begin
          d.rdata = '0;
          d.rdata[`COSC_S_CPU +: `COSC_NCPU] = q.cpu_stop;
          d.rdata[`COSC_S_PD] = pd_act;
          d.rdata[`COSC_S_PLL] = q.pll_en;
          d.rdata[`COSC_S_ST +: 7] = q.st;
        end
        `COSC_OFF_ID: begin
          d.rdata = `COSC_ID_VAL;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
    if (!q.wait_r && avs_write && avs_address == `COSC_OFF_CTRL) begin
      if (avs_byteenable[0]) begin
        d.ctrl[`COSC_BE0_HI:0] = avs_writedata[`COSC_BE0_HI:0];
      end
      if (avs_byteenable[1]) begin
        d.ctrl[`COSC_CW-1:`COSC_BE1_LO] = avs_writedata[`COSC_CW-1:`COSC_BE1_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.pd_s1 <= 1'b1;
      q.pd_s2 <= 1'b1;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.ps_s1 <= 1'b1;
      q.ps_s2 <= 1'b1;
      q.st <= COSC_RUN;
      q.free_running_pci_clk_run <= '1;
      q.pci_run <= 1'b1;
      q.b66_run <= 1'b1;
      q.dual_run <= 1'b1;
      q.usb_run <= 1'b1;
      q.ref_run <= 1'b1;
      q.cpu_t_oe <= '1;
      q.cpu_c_oe <= '1;
      q.pll_en <= 1'b1;
      // RL3 66 MHz mode at power-up
      // RL21 down spread 0.50 percent at power-up
      q.ctrl <= `COSC_CTRL_RST;
      q.ss_depth <= `COSC_SS_DEPTH_RST;
      q.wait_r <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from the state register
  // ------------------------------------------------------------
  assign avs_readdata           = q.rdata;
  assign avs_waitrequest        = q.wait_r;
  assign free_running_pci_clk   = q.free_running_pci_clk_o;
  assign pci_clk                = q.pci_o;
  assign buffered_66m_clk       = q.b66_o;
  assign dual_function_clk_out  = q.dual_o;
  assign usb_48m_clk            = q.usb_o;
  assign ref_clk                = q.ref_o;
  assign cpu_clk_true           = q.cpu_t;
  assign cpu_clk_true_oe        = q.cpu_t_oe;
  assign cpu_clk_complement     = q.cpu_c;
  assign cpu_clk_complement_oe  = q.cpu_c_oe;
  assign cpu_true_iref_x2       = q.iref2;
  assign osc_pll_enable         = q.pll_en;
  assign spread_center          = q.ss_center;
  assign spread_depth           = q.ss_depth;
  assign spread_modulation      = q.ss_en;
  assign dual_spread_modulation = q.dual_ss;

endmodule : cosc_top

// *** cosc_top_chk.sv ***
// port assertions for the clock stop and spread block
`timescale 1ns/1ps
`include "cosc_defs.svh"
module cosc_top_chk #(
  parameter int unsigned PD_WAKE_CYC = 20
) (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic [`COSC_AW-1:0]     avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic                    avs_waitrequest,
  input wire logic                    power_down_n,
  input wire logic                    cpu_clock_stop_n,
  input wire logic                    b66_src,
  input wire logic                    m48_src,
  input wire logic                    ref_src,
  input wire logic [`COSC_NPCIF-1:0]  free_running_pci_clk,
  input wire logic                    pci_clk,
  input wire logic                    buffered_66m_clk,
  input wire logic                    dual_function_clk_out,
  input wire logic                    usb_48m_clk,
  input wire logic                    ref_clk,
  input wire logic [`COSC_NCPU-1:0]   cpu_clk_true,
  input wire logic [`COSC_NCPU-1:0]   cpu_clk_complement,
  input wire logic [`COSC_NCPU-1:0]   cpu_clk_complement_oe,
  input wire logic                    cpu_true_iref_x2,
  input wire logic                    osc_pll_enable,
  input wire logic                    spread_center,
  input wire logic [1:0]              spread_depth,
  input wire logic                    spread_modulation
);
  logic [31:0] hi_q;
  logic        run_ok;
  // ----------------------------------------
  // helper: cycles since power-down release
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !power_down_n)
      hi_q <= '0;
    else if (hi_q != 32'hFFFF_FFFF)
      hi_q <= hi_q + 32'h1;
  end
  // wake time plus margin for the stop sequence
  assign run_ok = hi_q > PD_WAKE_CYC + 200;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bus answers one cycle after a request is taken
  AST_ACK_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  AST_PD_LOW: assert property (!osc_pll_enable |-> !(|free_running_pci_clk) && !pci_clk && !buffered_66m_clk
    && !usb_48m_clk && !ref_clk && !dual_function_clk_out) else $error("clock running with pll off");
  AST_PD_CPU: assert property (!osc_pll_enable |-> cpu_true_iref_x2 && !(|cpu_clk_complement_oe)
    && !(|cpu_clk_complement)) else $error("cpu pair wrong in power-down");
  AST_PD_SYNC: assert property ($rose(cpu_true_iref_x2) |-> !$past(power_down_n, 2))
    else $error("power-down acted before synchronizing");
  AST_WAKE: assert property (run_ok |-> osc_pll_enable && !cpu_true_iref_x2)
    else $error("generator not running after wake time");
  AST_OTHERS_RUN: assert property (run_ok |-> buffered_66m_clk == $past(b66_src)
    && usb_48m_clk == $past(m48_src) && ref_clk == $past(ref_src)) else $error("output not following source");
  AST_SPREAD_WR: assert property ($changed({spread_center, spread_depth}) |->
    $past(avs_write && !avs_waitrequest && avs_address == `COSC_OFF_CTRL, 2)) else $error("spread changed without write");
  AST_SPREAD_RST: assert property ($past(rst) |-> !spread_center && spread_depth == 2'b01
    && !spread_modulation) else $error("spread reset value wrong");
  AST_CPU_STOPPED: assert property (!cpu_true_iref_x2 && osc_pll_enable |->
    (cpu_clk_complement_oe | cpu_clk_true) == 3'h7 && (cpu_clk_complement_oe | ~cpu_clk_complement) == 3'h7)
    else $error("stopped cpu pair levels wrong");
  AST_CPU_SYNC: assert property ($fell(cpu_clk_complement_oe[0]) && !cpu_true_iref_x2 |->
    !$past(cpu_clock_stop_n, 3)) else $error("cpu pair stopped too early");
  AST_CPU_RESUME: assert property ($rose(cpu_clock_stop_n) && power_down_n && !cpu_true_iref_x2 |->
    ##[1:30] (&cpu_clk_complement_oe)) else $error("cpu pair restart late");
endmodule : cosc_top_chk

bind cosc_top cosc_top_chk #(.PD_WAKE_CYC(PD_WAKE_CYC)) u_chk (.*);

// *** cosc_pm_model.sv ***
// controller-side model driving the stop pins and source clocks
`timescale 1ns/1ps
module cosc_pm_model (
  input  wire logic sys_clk,
  input  wire logic pd_req,
  input  wire logic cs_req,
  input  wire logic ps_req,
  input  wire logic slow,
  output logic      power_down_n,
  output logic      cpu_clock_stop_n,
  output logic      pci_clock_stop_n,
  output logic      cpu_src,
  output logic      free_running_pci_clk_src,
  output logic      b66_src,
  output logic      m66_src,
  output logic      m48_src,
  output logic      pci_src,
  output logic      ref_src
);
  logic [2:0]  p1_q = 3'h0;
  logic [2:0]  p2_q = 3'h0;
  logic [2:0]  p3_q = 3'h0;
  int unsigned cnt_q = 0;
  // request pipe: prompt answers use one stage, slow ones three
  always @(posedge sys_clk) begin
    p1_q <= {pd_req, cs_req, ps_req};
    p2_q <= p1_q;
    p3_q <= p2_q;
    cnt_q <= cnt_q + 1;
  end
  // stop pins are active low
  assign {power_down_n, cpu_clock_stop_n, pci_clock_stop_n} = ~(slow ? p3_q : p1_q);
  // free-running sources, each half period several system cycles
  assign cpu_src  = (cnt_q / 6) % 2 == 1;
  assign free_running_pci_clk_src = (cnt_q / 12) % 2 == 1;
  assign pci_src  = (cnt_q / 12) % 2 == 1;
  assign b66_src  = (cnt_q / 8) % 2 == 1;
  assign m66_src  = (cnt_q / 8) % 2 == 1;
  assign m48_src  = (cnt_q / 10) % 2 == 1;
  assign ref_src  = (cnt_q / 14) % 2 == 1;
endmodule : cosc_pm_model

// *** test_clock_output_stop_and_spread_control.sv ***
// self-checking bench for the clock stop and spread block
`timescale 1ns/1ps
`include "cosc_defs.svh"
module test_clock_output_stop_and_spread_control;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic [`COSC_AW-1:0] avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = '0;
  logic [3:0]          avs_byteenable = '0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest, power_down_n, cpu_clock_stop_n, pci_clock_stop_n;
  logic                cpu_src, free_running_pci_clk_src, b66_src, m66_src, m48_src, pci_src, ref_src;
  logic [2:0]          free_running_pci_clk, cpu_clk_true, cpu_clk_true_oe, cpu_clk_complement, cpu_clk_complement_oe;
  logic                pci_clk, buffered_66m_clk, dual_function_clk_out, usb_48m_clk, ref_clk;
  logic                cpu_true_iref_x2, osc_pll_enable, spread_center, spread_modulation, dual_spread_modulation;
  logic [1:0]          spread_depth;
  logic                pd_req = 1'b0, cs_req = 1'b0, ps_req = 1'b0, slow = 1'b0;
  logic [31:0]         ctrl_m = 32'(`COSC_CTRL_RST);
  int                  fails = 0, check_count = 0, cyc = 0, ones[3];

  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 4000) begin
      fails++;
      tally_and_finish();
    end
  end

  cosc_top #(.PD_WAKE_CYC(20)) DUT (.*);

  cosc_pm_model u_pm (.*);

  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // write and keep the control model in step
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    bus(1'b1, a, d, be, r);
    if (a == `COSC_OFF_CTRL && be[0]) ctrl_m[7:0] = d[7:0];
    if (a == `COSC_OFF_CTRL && be[1]) ctrl_m[12:8] = d[12:8];
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(r, e);
  endtask : rd

  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    void'($urandom(49161));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`COSC_OFF_CTRL, ctrl_m);
    wr(`COSC_OFF_ID, 32'hFFFF_FFFF, 4'hF);
    wr(4'hC, 32'hFFFF_FFFF, 4'hF);
    rd(`COSC_OFF_ID, `COSC_ID_VAL);
    rd(4'hC, 32'h0);
    rd(`COSC_OFF_STAT, 32'h30);
    // every spread code with random mode and lanes
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      d[3:1] = i[2:0];
      wr(`COSC_OFF_CTRL, d, {2'b00, d[20], 1'b1});
      repeat (2) @(posedge sys_clk);
      chk({27'h0, spread_center, spread_depth, spread_modulation, dual_spread_modulation},
          {27'h0, ctrl_m[3], ctrl_m[2:1], ctrl_m[4], ctrl_m[4] & ~ctrl_m[0]});
      rd(`COSC_OFF_CTRL, ctrl_m);
    end
    // controller picks 48 MHz mode, pairs 0 and 2 stoppable
    wr(`COSC_OFF_CTRL, 32'h281, 4'h3);
    repeat (30) @(posedge sys_clk);
    repeat (20) begin
      @(posedge sys_clk);
      chk({31'h0, dual_function_clk_out}, {31'h0, usb_48m_clk});
    end
    // cpu stop, driven then three-stated, prompt then slow
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(`COSC_OFF_CTRL, 32'h281 | (s << 6), 4'h3);
      cs_req <= 1'b1;
      repeat (80) @(posedge sys_clk);
      chk({23'h0, cpu_clk_complement_oe, cpu_clk_true_oe, cpu_clk_true & 3'h5},
          {23'h0, 3'h2, (s == 1) ? 3'h2 : 3'h7, 3'h5});
      rd(`COSC_OFF_STAT, 32'h35);
      cs_req <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk({29'h0, cpu_clk_complement_oe}, 32'h7);
    end
    // stoppable free pci outputs follow the stop pin
    wr(`COSC_OFF_CTRL, 32'hC81, 4'h3);
    ps_req <= 1'b1;
    repeat (40) @(posedge sys_clk);
    ones = '{0, 0, 0};
    repeat (48) begin
      @(posedge sys_clk);
      ones[0] += pci_clk;
      ones[1] += |free_running_pci_clk[1:0];
      ones[2] += free_running_pci_clk[2];
    end
    chk(ones[0] + ones[1], 0);
    chk(ones[2] > 0, 1);
    ps_req <= 1'b0;
    pd_req <= 1'b1;
    repeat (300) @(posedge sys_clk);
    chk({16'h0, free_running_pci_clk, pci_clk, buffered_66m_clk, dual_function_clk_out, usb_48m_clk, ref_clk,
         osc_pll_enable, cpu_true_iref_x2, cpu_clk_complement_oe, cpu_clk_true}, 32'h47);
    pd_req <= 1'b0;
    repeat (260) @(posedge sys_clk);
    chk({30'h0, osc_pll_enable, cpu_true_iref_x2}, 32'h2);
    rd(`COSC_OFF_STAT, 32'h30);
    tally_and_finish();
  end
endmodule : test_clock_output_stop_and_spread_control
